// ===== rtl/css_pkg.sv
// constants, field layouts and carrier types for the subtract/swap/xor core
package css_pkg;

  // ------------------------------------------------------------
  // widths
  // ------------------------------------------------------------
  localparam int unsigned DATA_W = 8;   // core data width
  localparam int unsigned FADDR_W = 7;  // file address width, 0..127
  localparam int unsigned PADDR_W = 8;  // apb byte address width
  localparam int unsigned PDATA_W = 32; // apb data width

  // ------------------------------------------------------------
  // apb register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;  // instruction issue, reads back
  localparam logic [7:0] OFF_WREG = 8'h04;   // working register
  localparam logic [7:0] OFF_STATUS = 8'h08; // flags, sleep, busy
  localparam logic [7:0] OFF_FDATA = 8'h0c;  // file register at the file pointer
  localparam logic [7:0] OFF_FADDR = 8'h10;  // file pointer
  localparam logic [7:0] OFF_DIR_A = 8'h14;  // port a direction, read only
  localparam logic [7:0] OFF_DIR_B = 8'h18;  // port b direction, read only
  localparam logic [7:0] OFF_DIR_C = 8'h1c;  // port c direction, read only
  localparam logic [7:0] OFF_WDOG = 8'h20;   // watchdog counter, read only

  // ------------------------------------------------------------
  // instruction word field positions
  // ------------------------------------------------------------
  localparam int unsigned INS_OP_LSB = 0;     // opcode, 4 bits
  localparam int unsigned INS_DEST_BIT = 4;   // destination bit
  localparam int unsigned INS_FADDR_LSB = 8;  // file address, 7 bits
  localparam int unsigned INS_LIT_LSB = 16;   // literal, 8 bits

  // ------------------------------------------------------------
  // opcodes
  // ------------------------------------------------------------
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_SLEEP = 4'h1;
  localparam logic [3:0] OP_SUBTRACT_WREG_FROM_LITERAL = 4'h2;
  localparam logic [3:0] OP_SUBTRACT_WREG_FROM_FILE = 4'h3;
  localparam logic [3:0] OP_SUBTRACT_WREG_FROM_FILE_BORROW = 4'h4;
  localparam logic [3:0] OP_SWAP_FILE_NIBBLES = 4'h5;
  localparam logic [3:0] OP_LOAD_PORT_DIRECTION = 4'h6;
  localparam logic [3:0] OP_XOR_LITERAL_INTO_WREG = 4'h7;
  localparam logic [3:0] OP_XOR_WREG_WITH_FILE = 4'h8;

  // ------------------------------------------------------------
  // status register bit positions
  // ------------------------------------------------------------
  localparam int unsigned SB_CARRY = 0;
  localparam int unsigned SB_DIGIT_CARRY = 1;
  localparam int unsigned SB_ZERO = 2;
  localparam int unsigned SB_POWER_DOWN = 3;
  localparam int unsigned SB_TIME_OUT = 4;
  localparam int unsigned SB_SLEEP = 5;
  localparam int unsigned SB_BUSY = 6;

  // ------------------------------------------------------------
  // direction-load operands and reset values
  // ------------------------------------------------------------
  localparam logic [6:0] DIR_SEL_A = 7'h05;
  localparam logic [6:0] DIR_SEL_B = 7'h06;
  localparam logic [6:0] DIR_SEL_C = 7'h07;
  localparam logic [7:0] RST_DIR = 8'hff;  // all pins input after reset
  localparam logic [7:0] RST_WREG = 8'h00;
  localparam logic RST_POWER_DOWN = 1'b1;
  localparam logic RST_TIME_OUT = 1'b1;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam int unsigned WDOG_PRESC_W = 8; // prescaler width

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0] lit;    // literal k
    logic [6:0] faddr;  // file address f
    logic dest;         // 0 to working register, 1 to file
    logic [3:0] op;     // opcode
  } css_instr_t;

  typedef struct packed {
    logic carry;
    logic digit_carry;
    logic zero;
    logic power_down_flag; // low after a sleep
    logic time_out_flag;   // high after a sleep
  } css_flags_t;

  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} css_state_t;

endpackage

// ===== rtl/css_file_ram.sv
// file register memory, one write port and one registered read port
`timescale 1ns/100ps
module css_file_ram #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic core_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);

  // storage, no reset: contents are undefined until written
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ------------------------------------------------------------
  // write and registered read
  // ------------------------------------------------------------
  // write-through so a read of the word being written sees the new value
  always_ff @(posedge core_clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr))
    begin
      rdata <= wdata;
    end
    else
    begin
      rdata <= mem[raddr];
    end
  end

endmodule // css_file_ram

// ===== rtl/css_core.sv
// subtract, swap, xor, direction-load and sleep execution core with apb access
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module css_core
  import css_pkg::*;
#(
  parameter int unsigned WDOG_W = 8 // watchdog counter width
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [css_pkg::PADDR_W-1:0] paddr,
  input wire logic [css_pkg::PDATA_W-1:0] pwdata,
  output logic [css_pkg::PDATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [css_pkg::DATA_W-1:0] port_a_direction,
  output logic [css_pkg::DATA_W-1:0] port_b_direction,
  output logic [css_pkg::DATA_W-1:0] port_c_direction,
  output logic sleep_mode,
  output logic osc_run
);
  import css_pkg::*;

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  // a - b - !cin as a + ~b + cin; returns {carry, digit carry, result}
  function automatic logic [9:0] css_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction
  // zero test shared by the subtract and xor flag updates
  function automatic logic css_is_zero(input logic [7:0] v);
    return (v == 8'h00);
  endfunction
  // offsets that answer without error; the map is dense and word aligned
  function automatic logic css_mapped(input logic [7:0] a);
    return (a <= OFF_WDOG) && (a[1:0] == 2'h0);
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  css_state_t state, next_state;      // instruction sequencer
  css_instr_t instr, next_instr;      // last issued instruction
  css_flags_t flags, next_flags;      // status flags
  logic [7:0] wreg, next_wreg;        // working register
  logic sleep, next_sleep;            // low-power state
  logic [7:0] dir_a, next_dir_a;      // port a direction
  logic [7:0] dir_b, next_dir_b;      // port b direction
  logic [7:0] dir_c, next_dir_c;      // port c direction
  logic [6:0] faddr, next_faddr;      // software file pointer
  logic [31:0] rdata_q, next_rdata_q; // captured read data
  logic rd_wait, next_rd_wait;        // read data captured, answer next
  logic [WDOG_PRESC_W-1:0] presc, next_presc; // watchdog prescaler
  logic [WDOG_W-1:0] wdog, next_wdog; // watchdog counter
  // ------------------------------------------------------------
  // file memory wiring
  // ------------------------------------------------------------
  logic ram_we;
  logic [6:0] ram_waddr;
  logic [7:0] ram_wdata;
  logic [6:0] ram_raddr;
  logic [7:0] ram_rdata;

  // the sequencer owns the read port only while fetching an operand
  assign ram_raddr = (state == ST_FETCH) ? instr.faddr : faddr;
  css_file_ram #(.AW(FADDR_W), .DW(DATA_W)) u_ram (
    .core_clk(core_clk), .we(ram_we), .waddr(ram_waddr),
    .wdata(ram_wdata), .raddr(ram_raddr), .rdata(ram_rdata)
  );

  // ------------------------------------------------------------
  // apb handshake
  // ------------------------------------------------------------
  logic idle;    // no instruction in flight
  logic acc;     // access phase
  logic wr_done; // write completes this edge
  assign idle = (state == ST_IDLE);
  assign acc = psel & penable;
  // when idle, writes finish in the first access cycle and reads need one wait for capture
  assign pready = acc & idle & (pwrite | rd_wait);
  assign pslverr = pready & ~css_mapped(paddr);
  assign wr_done = pready & pwrite;
  assign prdata = rdata_q;
  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign port_a_direction = dir_a;
  assign port_b_direction = dir_b;
  assign port_c_direction = dir_c;
  assign sleep_mode = sleep;
  assign osc_run = ~sleep;

  // ------------------------------------------------------------
  // next-state logic: sequencer, datapath and registers
  // ------------------------------------------------------------
  always_comb
  begin
    logic [9:0] sub_r;  // subtract result with carries
    logic [7:0] opnd;   // file operand
    logic [7:0] res;    // result headed for the destination
    logic to_dest;      // result goes to the d-selected target
    logic wdog_clr;     // sleep clears the watchdog
    logic [31:0] rmux;  // read data selected by address
    sub_r = 10'h000;
    opnd = ram_rdata;
    res = 8'h00;
    to_dest = 1'b0;
    wdog_clr = 1'b0;
    rmux = 32'h0000_0000;
    next_state = state;
    next_instr = instr;
    next_flags = flags;
    next_wreg = wreg;
    next_sleep = sleep;
    next_dir_a = dir_a;
    next_dir_b = dir_b;
    next_dir_c = dir_c;
    next_faddr = faddr;
    next_rdata_q = rdata_q;
    next_rd_wait = rd_wait;
    ram_we = 1'b0;
    ram_waddr = faddr;
    ram_wdata = pwdata[7:0];
    // sequencer
    unique case (state)
      ST_IDLE:
      begin
        // instructions are ignored while asleep: the clock is notionally stopped
        if (wr_done && (paddr == OFF_INSTR) && !sleep)
        begin
          next_instr.op = pwdata[INS_OP_LSB +: 4];
          next_instr.dest = pwdata[INS_DEST_BIT];
          next_instr.faddr = pwdata[INS_FADDR_LSB +: 7];
          next_instr.lit = pwdata[INS_LIT_LSB +: 8];
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: next_state = ST_EXEC; // operand read issued here, valid in exec
      ST_EXEC:
      begin
        next_state = ST_IDLE;
        case (instr.op)
          OP_SLEEP:
          begin
            next_flags.power_down_flag = 1'b0;
            next_flags.time_out_flag = 1'b1;
            wdog_clr = 1'b1;
            next_sleep = 1'b1;
          end
          OP_SUBTRACT_WREG_FROM_LITERAL:
          begin
            sub_r = css_sub(instr.lit, wreg, 1'b1);
            next_wreg = sub_r[7:0];
          end
          OP_SUBTRACT_WREG_FROM_FILE:
          begin
            sub_r = css_sub(opnd, wreg, 1'b1);
            res = sub_r[7:0];
            to_dest = 1'b1;
          end
          OP_SUBTRACT_WREG_FROM_FILE_BORROW:
          begin
            // borrow is the inverted carry, so carry feeds in directly
            sub_r = css_sub(opnd, wreg, flags.carry);
            res = sub_r[7:0];
            to_dest = 1'b1;
          end
          OP_SWAP_FILE_NIBBLES:
          begin
            res = {opnd[3:0], opnd[7:4]};
            to_dest = 1'b1;
          end
          OP_LOAD_PORT_DIRECTION:
          begin
            // other operands load nothing
            if (instr.faddr == DIR_SEL_A)
              next_dir_a = wreg;
            else if (instr.faddr == DIR_SEL_B)
              next_dir_b = wreg;
            else if (instr.faddr == DIR_SEL_C)
              next_dir_c = wreg;
          end
          OP_XOR_LITERAL_INTO_WREG:
          begin
            next_wreg = wreg ^ instr.lit;
            next_flags.zero = css_is_zero(wreg ^ instr.lit);
          end
          OP_XOR_WREG_WITH_FILE:
          begin
            res = wreg ^ opnd;
            to_dest = 1'b1;
            next_flags.zero = css_is_zero(res);
          end
          default: next_state = ST_IDLE; // nop and unused codes change nothing else
        endcase
        // all three subtracts share the flag update
        if ((instr.op == OP_SUBTRACT_WREG_FROM_LITERAL) ||
            (instr.op == OP_SUBTRACT_WREG_FROM_FILE) ||
            (instr.op == OP_SUBTRACT_WREG_FROM_FILE_BORROW))
        begin
          next_flags.carry = sub_r[9];
          next_flags.digit_carry = sub_r[8];
          next_flags.zero = css_is_zero(sub_r[7:0]);
        end
        // destination select for file operations
        if (to_dest)
        begin
          if (instr.dest)
          begin
            ram_we = 1'b1;
            ram_waddr = instr.faddr;
            ram_wdata = res;
          end
          else
            next_wreg = res;
        end
      end
    endcase
    // software register writes, only ever while idle
    if (wr_done)
    begin
      if (paddr == OFF_WREG)
        next_wreg = pwdata[7:0];
      else if (paddr == OFF_STATUS)
      begin
        next_flags.carry = pwdata[SB_CARRY];
        next_flags.digit_carry = pwdata[SB_DIGIT_CARRY];
        next_flags.zero = pwdata[SB_ZERO];
        // writing one to the sleep bit wakes the core
        if (pwdata[SB_SLEEP])
          next_sleep = 1'b0;
      end
      else if (paddr == OFF_FADDR)
        next_faddr = pwdata[6:0];
      else if (paddr == OFF_FDATA)
      begin
        ram_we = 1'b1;
        ram_waddr = faddr;
        ram_wdata = pwdata[7:0];
      end
    end
    // read mux
    case (paddr)
      OFF_INSTR: rmux = {8'h00, instr.lit, 1'b0, instr.faddr, 3'h0, instr.dest, instr.op};
      OFF_WREG: rmux = {24'h000000, wreg};
      OFF_STATUS: rmux = {25'h0000000, ~idle, sleep, flags.time_out_flag, flags.power_down_flag,
                          flags.zero, flags.digit_carry, flags.carry};
      OFF_FDATA: rmux = {24'h000000, ram_rdata};
      OFF_FADDR: rmux = {25'h0000000, faddr};
      OFF_DIR_A: rmux = {24'h000000, dir_a};
      OFF_DIR_B: rmux = {24'h000000, dir_b};
      OFF_DIR_C: rmux = {24'h000000, dir_c};
      OFF_WDOG: rmux = {{(32-WDOG_W){1'b0}}, wdog};
      default: rmux = 32'h0000_0000; // unmapped reads zero
    endcase
    // read capture: first idle access cycle latches, the next one answers
    if (acc && !pwrite && idle && !rd_wait)
    begin
      next_rdata_q = rmux;
      next_rd_wait = 1'b1;
    end
    else if (pready)
      next_rd_wait = 1'b0;
    // watchdog: free running; it keeps counting in sleep, nothing here acts on it
    next_presc = presc + 1'b1;
    next_wdog = (presc == {WDOG_PRESC_W{1'b1}}) ? wdog + 1'b1 : wdog;
    if (wdog_clr)
    begin
      next_presc = '0;
      next_wdog = WDOG_CLEAR[WDOG_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      instr <= '0;
      flags <= '{carry: 1'b0, digit_carry: 1'b0, zero: 1'b0,
                 power_down_flag: RST_POWER_DOWN, time_out_flag: RST_TIME_OUT};
      wreg <= RST_WREG;
      sleep <= 1'b0;
      dir_a <= RST_DIR;
      dir_b <= RST_DIR;
      dir_c <= RST_DIR;
      faddr <= '0;
      rdata_q <= 32'h0000_0000;
      rd_wait <= 1'b0;
      presc <= '0;
      wdog <= '0;
    end
    else
    begin
      state <= next_state;
      instr <= next_instr;
      flags <= next_flags;
      wreg <= next_wreg;
      sleep <= next_sleep;
      dir_a <= next_dir_a;
      dir_b <= next_dir_b;
      dir_c <= next_dir_c;
      faddr <= next_faddr;
      rdata_q <= next_rdata_q;
      rd_wait <= next_rd_wait;
      presc <= next_presc;
      wdog <= next_wdog;
    end
  end

endmodule // css_core

// ===== tb/css_core_chk.sv
// port-level assertion checker for the subtract/swap/xor core
`timescale 1ns/100ps
module css_core_chk
  import css_pkg::*;
#(
  parameter int unsigned WDOG_W = 8 // watchdog counter width
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [css_pkg::PADDR_W-1:0] paddr,
  input wire logic [css_pkg::PDATA_W-1:0] pwdata,
  input wire logic [css_pkg::PDATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [css_pkg::DATA_W-1:0] port_a_direction,
  input wire logic [css_pkg::DATA_W-1:0] port_b_direction,
  input wire logic [css_pkg::DATA_W-1:0] port_c_direction,
  input wire logic sleep_mode,
  input wire logic osc_run
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  logic done; // transfer completes at this edge
  logic ins_go; // instruction issued
  logic ld; // direction load issued
  logic [2:0] hist_a, hist_b, hist_c; // recent loads, spans the 3-cycle run
  logic [7:0] sl_cnt; // cycles asleep, saturating
  assign done = psel & penable & pready;
  assign ins_go = done & pwrite & (paddr == OFF_INSTR);
  assign ld = ins_go & (pwdata[3:0] == OP_LOAD_PORT_DIRECTION);
  // history shifters and sleep age counter
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hist_a <= 3'h0;
      hist_b <= 3'h0;
      hist_c <= 3'h0;
      sl_cnt <= 8'h00;
    end
    else
    begin
      hist_a <= {hist_a[1:0], ld & (pwdata[14:8] == DIR_SEL_A)};
      hist_b <= {hist_b[1:0], ld & (pwdata[14:8] == DIR_SEL_B)};
      hist_c <= {hist_c[1:0], ld & (pwdata[14:8] == DIR_SEL_C)};
      // saturate so a long sleep never wraps back into the window
      sl_cnt <= !sleep_mode ? 8'h00 : (sl_cnt == 8'hff ? sl_cnt : sl_cnt + 8'h01);
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  property p_osc_stop;
    osc_run == !sleep_mode;
  endproperty
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator state disagrees with sleep");
  property p_sleep_entry;
    ins_go && pwdata[3:0] == OP_SLEEP && !sleep_mode |-> ##[1:3] sleep_mode;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("sleep not entered after sleep instruction");
  property p_sleep_flags;
    done && !pwrite && paddr == OFF_STATUS && sleep_mode
      |-> !prdata[SB_POWER_DOWN] && prdata[SB_TIME_OUT] && prdata[SB_SLEEP];
  endproperty
  a_sleep_flags: assert property (p_sleep_flags)
    else $error("status flags wrong while asleep");
  property p_wdog_clear;
    done && !pwrite && paddr == OFF_WDOG && sleep_mode && sl_cnt < 8'd200
      |-> prdata[WDOG_W-1:0] == '0;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear)
    else $error("watchdog not cleared by sleep");
  property p_dir_a;
    $changed(port_a_direction) |-> |hist_a;
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("port a direction changed without its load");
  property p_dir_b;
    $changed(port_b_direction) |-> |hist_b;
  endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("port b direction changed without its load");
  property p_dir_c;
    $changed(port_c_direction) |-> |hist_c;
  endproperty
  a_dir_c: assert property (p_dir_c)
    else $error("port c direction changed without its load");
  property p_unmapped;
    done && paddr > OFF_WDOG |-> pslverr && prdata == '0 || pwrite && pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");
endmodule // css_core_chk

bind css_core css_core_chk #(.WDOG_W(WDOG_W)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .port_a_direction(port_a_direction),
  .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
  .sleep_mode(sleep_mode), .osc_run(osc_run)
);

// ===== tb/tb_top.sv
// self-checking bench for the subtract/swap/xor core
`timescale 1ns/100ps
module tb_top;
  import css_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [PADDR_W-1:0] paddr = '0;
  logic [PDATA_W-1:0] pwdata = '0;
  logic [PDATA_W-1:0] prdata;
  logic pready, pslverr, sleep_mode, osc_run;
  logic [DATA_W-1:0] dir_a, dir_b, dir_c;
  logic [7:0] dirs [3]; // expected directions
  logic [31:0] rdat; // last read data
  logic rerr; // last error response
  int n_fail = 0;
  int tests_run = 0;
  always #5 core_clk = ~core_clk;
  css_core #(.WDOG_W(8)) uut (
    .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_direction(dir_a),
    .port_b_direction(dir_b), .port_c_direction(dir_c),
    .sleep_mode(sleep_mode), .osc_run(osc_run)
  );
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic test_done;
  begin
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  end
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
  begin
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  end
  endtask
  // one apb transfer; values read right after the edge are still pre-edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  // loads operands, presets zero opposite to the outcome, carry to cin and digit carry to its inverse, runs one op
  task automatic alu_case(input logic [3:0] op, input logic d, input logic [6:0] fa,
                          input logic [7:0] k, input logic [7:0] fv, input logic [7:0] w,
                          input logic cin);
    logic [7:0] res;
    logic c, dc, z, zp, lit;
  begin
    c = cin;
    dc = ~cin;
    lit = (op == OP_SUBTRACT_WREG_FROM_LITERAL) || (op == OP_XOR_LITERAL_INTO_WREG);
    case (op)
      OP_SUBTRACT_WREG_FROM_LITERAL:
      begin
        res = k - w;
        c = (w <= k);
        dc = (w[3:0] <= k[3:0]);
      end
      OP_SUBTRACT_WREG_FROM_FILE:
      begin
        res = fv - w;
        c = (w <= fv);
        dc = (w[3:0] <= fv[3:0]);
      end
      OP_SUBTRACT_WREG_FROM_FILE_BORROW:
      begin
        res = fv - w - 8'(!cin);
        c = (9'(w) + 9'(!cin)) <= 9'(fv);
        dc = (5'(w[3:0]) + 5'(!cin)) <= 5'(fv[3:0]);
      end
      OP_SWAP_FILE_NIBBLES: res = {fv[3:0], fv[7:4]};
      OP_XOR_LITERAL_INTO_WREG: res = w ^ k;
      default: res = w ^ fv;
    endcase
    zp = (res != 8'h00);
    z = (op == OP_SWAP_FILE_NIBBLES) ? zp : ~zp;
    apb(1'b1, OFF_FADDR, {25'h0, fa});
    apb(1'b1, OFF_FDATA, {24'h0, fv});
    apb(1'b1, OFF_WREG, {24'h0, w});
    apb(1'b1, OFF_STATUS, {29'h0, zp, ~cin, cin});
    apb(1'b1, OFF_INSTR, {8'h00, k, 1'b0, fa, 3'h0, d, op});
    apb(1'b0, OFF_WREG, 32'h0);
    chk("wreg", {24'h0, (d && !lit) ? w : res}, rdat);
    apb(1'b0, OFF_FDATA, 32'h0);
    chk("file", {24'h0, (d && !lit) ? res : fv}, rdat);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status", {24'h0, 3'h0, 2'h3, z, dc, c}, rdat);
  end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("status reset", 32'h18, rdat);
    apb(1'b0, 8'h24, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    alu_case(OP_SUBTRACT_WREG_FROM_LITERAL, 0, 7'h00, 8'h05, 8'h00, 8'h05, 0);
    alu_case(OP_SUBTRACT_WREG_FROM_LITERAL, 0, 7'h00, 8'h00, 8'h00, 8'h01, 1);
    alu_case(OP_SUBTRACT_WREG_FROM_LITERAL, 0, 7'h00, 8'hff, 8'h00, 8'h00, 0);
    alu_case(OP_SUBTRACT_WREG_FROM_LITERAL, 0, 7'h00, 8'h10, 8'h00, 8'h0f, 1);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE, 0, 7'h7f, 8'h00, 8'h80, 8'h7f, 0);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE, 1, 7'h00, 8'h00, 8'h3c, 8'h3c, 0);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE, 1, 7'h7f, 8'h00, 8'h10, 8'h21, 1);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE_BORROW, 0, 7'h11, 8'h00, 8'h50, 8'h20, 0);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE_BORROW, 1, 7'h22, 8'h00, 8'h00, 8'h00, 1);
    alu_case(OP_SUBTRACT_WREG_FROM_FILE_BORROW, 1, 7'h33, 8'h00, 8'h00, 8'h00, 0);
    alu_case(OP_SWAP_FILE_NIBBLES, 0, 7'h44, 8'h00, 8'ha5, 8'h00, 1);
    alu_case(OP_SWAP_FILE_NIBBLES, 1, 7'h55, 8'h00, 8'h3c, 8'h99, 0);
    alu_case(OP_XOR_LITERAL_INTO_WREG, 0, 7'h00, 8'hff, 8'h00, 8'hff, 1);
    alu_case(OP_XOR_LITERAL_INTO_WREG, 0, 7'h00, 8'h0f, 8'h00, 8'hf0, 0);
    alu_case(OP_XOR_WREG_WITH_FILE, 0, 7'h66, 8'h00, 8'h55, 8'h55, 0);
    alu_case(OP_XOR_WREG_WITH_FILE, 1, 7'h7f, 8'h00, 8'h5a, 8'ha5, 1);
    // direction loads; operand 4 must leave all three alone
    dirs = '{8'hff, 8'hff, 8'hff};
    apb(1'b1, OFF_STATUS, 32'h7);
    for (int s = 4; s < 8; s++)
    begin
      apb(1'b1, OFF_WREG, 32'(8'ha0 + 8'(s)));
      apb(1'b1, OFF_INSTR, {17'h0, 7'(s), 4'h0, OP_LOAD_PORT_DIRECTION});
      if (s > 4)
        dirs[s-5] = 8'ha0 + 8'(s);
      for (int i = 0; i < 3; i++)
      begin
        apb(1'b0, OFF_DIR_A + 8'(4 * i), 32'h0);
        chk("dir reg", {24'h0, dirs[i]}, rdat);
        chk("dir pin", {24'h0, dirs[i]},
            {24'h0, ((i == 0) ? dir_a : (i == 1) ? dir_b : dir_c)});
      end
    end
    apb(1'b0, OFF_INSTR, 32'h0);
    chk("instr readback", {17'h0, 7'h07, 4'h0, OP_LOAD_PORT_DIRECTION}, rdat);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("dir flags", 32'h1f, rdat);
    apb(1'b1, OFF_DIR_A, 32'h0);
    apb(1'b0, OFF_DIR_A, 32'h0);
    chk("dir read only", {24'h0, dirs[0]}, rdat);
    // sleep: let the watchdog advance first so clearing is visible
    repeat (600) @(posedge core_clk);
    apb(1'b0, OFF_WDOG, 32'h0);
    chk("wdog running", 32'h1, 32'(rdat != 32'h0));
    apb(1'b1, OFF_INSTR, {28'h0, OP_SLEEP});
    apb(1'b0, OFF_WDOG, 32'h0);
    chk("wdog cleared", 32'h0, rdat);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("sleep flags", 32'h30, rdat & 32'h78);
    chk("osc stopped", 32'h2, {30'h0, sleep_mode, osc_run});
    apb(1'b1, OFF_STATUS, 32'h20);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk("woken", 32'h0, rdat & 32'h20);
    test_done;
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    test_done;
  end
endmodule // tb_top
